// >>> core/cgc_pkg.sv
// constants and types shared by the core and cache clock generator
package cgc_pkg;

	// ==========================================================
	// clock and configuration codes
	localparam int CGC_CLK_PERIOD_NS = 10;
	localparam logic [3:0] CGC_CFG_BYPASS = 4'h3;
	localparam logic [3:0] CGC_CFG_OFF = 4'hf;

	// ==========================================================
	// cache clock divisor field of the cache control register
	localparam int CGC_FIELD_LSB = 4;
	localparam int CGC_FIELD_MSB = 6;
	localparam logic [2:0] CGC_DIV_NONE = 3'h0;
	localparam logic [2:0] CGC_DIV_1 = 3'h1;
	localparam logic [2:0] CGC_DIV_1P5 = 3'h2;
	localparam logic [2:0] CGC_DIV_2 = 3'h3;
	localparam logic [2:0] CGC_DIV_2P5 = 3'h4;
	localparam logic [2:0] CGC_DIV_3 = 3'h5;

	// divided period in ticks; one tick is half a core clock period
	localparam logic [2:0] CGC_TICKS_STOP = 3'h0;
	localparam logic [2:0] CGC_TICKS_DIV_1 = 3'h2;
	localparam logic [2:0] CGC_TICKS_DIV_1P5 = 3'h3;
	localparam logic [2:0] CGC_TICKS_DIV_2 = 3'h4;
	localparam logic [2:0] CGC_TICKS_DIV_2P5 = 3'h5;
	localparam logic [2:0] CGC_TICKS_DIV_3 = 3'h6;
	localparam int CGC_MAX_TICKS = 6;

	// ==========================================================
	// delay loop
	localparam logic [2:0] CGC_TAP_RESET = 3'h0;
	localparam logic [3:0] CGC_LOCK_HITS = 4'h8;

	typedef enum logic [1:0] {
		CGC_MODE_PLL = 2'b00,
		CGC_MODE_BYPASS = 2'b01,
		CGC_MODE_OFF = 2'b10
	} cgc_mode_t;

endpackage

// >>> core/cgc_dll_if.sv
// link between the clock divider and the delay loop
`timescale 1ns/100ps
interface cgc_dll_if;
	logic run;
	logic [2:0] period;
	logic ref_clk;
	logic sync_in;
	logic dly_clk;
	logic [2:0] tap;
	logic locked;

	modport ctrl (
		output run,
		output period,
		output ref_clk,
		output sync_in,
		input dly_clk,
		input tap,
		input locked
	);

	modport dll (
		input run,
		input period,
		input ref_clk,
		input sync_in,
		output dly_clk,
		output tap,
		output locked
	);
endinterface

// >>> core/cgc_dll.sv
// delay loop that phase-aligns the divided cache clock to the returned sync
`timescale 1ns/100ps
module cgc_dll
	import cgc_pkg::*;
#(
	parameter int MAX_TAPS = CGC_MAX_TICKS
) (
	input wire logic core_clk,
	input wire logic rst,
	cgc_dll_if.dll lnk
);

	// a tap change needs a full trip through pads and board before it shows
	localparam int SETTLE_TICKS = 2 * MAX_TAPS;
	localparam int SW = $clog2(SETTLE_TICKS + 1);

	logic [MAX_TAPS-1:0] hist;
	logic ref_q;
	logic sync_q;
	logic [2:0] period_q;
	logic [3:0] hits;
	logic [2:0] tap;
	logic locked;
	logic dly_clk;
	logic ref_rise;
	logic sync_rise;
	logic restart;
	logic [SW-1:0] settle;
	logic sync_seen;

	assign ref_rise = lnk.ref_clk & ~ref_q;
	assign sync_rise = lnk.sync_in & ~sync_q;
	assign sync_seen = sync_rise & (settle == '0);
	// a new divisor makes the old tap meaningless
	assign restart = ~lnk.run | (period_q != lnk.period);
	assign lnk.dly_clk = dly_clk;
	assign lnk.tap = tap;
	assign lnk.locked = locked;

	// ==========================================================
	// edge history
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hist <= '0;
			ref_q <= 1'b0;
			sync_q <= 1'b0;
			period_q <= CGC_TICKS_STOP;
		end else begin
			hist <= {hist[MAX_TAPS-2:0], lnk.ref_clk};
			ref_q <= lnk.ref_clk;
			sync_q <= lnk.sync_in;
			period_q <= lnk.period;
		end
	end

	// ==========================================================
	// tap search: step one tap whenever a return seen after the settle window misses the edge
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			tap <= CGC_TAP_RESET;
		end else if (sync_seen && !ref_rise) begin
			// wraps within one divided period at most
			tap <= (3'(tap + 3'h1) >= lnk.period) ? CGC_TAP_RESET : 3'(tap + 3'h1); // [R10]
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			hits <= '0;
			locked <= 1'b0;
		end else if (sync_seen) begin
			if (ref_rise) begin // [R6]
				hits <= (hits == CGC_LOCK_HITS) ? hits : 4'(hits + 4'h1);
				locked <= locked | (hits == 4'(CGC_LOCK_HITS - 4'h1));
			end else begin
				hits <= '0;
				locked <= 1'b0;
			end
		end
	end

	// ==========================================================
	// settle window
	// stepping again on stale return edges would chase the tap round forever;
	// a round trip longer than the window is not tolerated
	always_ff @(posedge core_clk) begin
		if (rst || restart) begin
			settle <= SW'(SETTLE_TICKS);
		end else if (sync_seen && !ref_rise) begin
			settle <= SW'(SETTLE_TICKS); // [R10]
		end else if (settle != '0) begin
			settle <= SW'(settle - 1'b1);
		end
	end

	// ==========================================================
	// delay line output
	always_ff @(posedge core_clk) begin
		if (rst || !lnk.run) begin
			dly_clk <= 1'b0;
		end else begin
			dly_clk <= (tap == CGC_TAP_RESET) ? lnk.ref_clk : hist[3'(tap - 3'h1)]; // [R4] [R10]
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_tap_in_period: assert property (lnk.run && !restart |-> tap < lnk.period) // [R10]
		else $error("delay tap beyond one divided period");
	a_lock_on_align: assert property ($rose(locked) |-> $past(sync_seen && ref_rise)) // [R6]
		else $error("lock rose without an aligned return edge");
	a_miss_steps_tap: assert property (sync_seen && !ref_rise && !restart ##1 !restart
		|-> tap != $past(tap)) // [R10]
		else $error("missed return edge did not move the tap");
	a_idle_dll_quiet: assert property (!lnk.run |=> !dly_clk && tap == CGC_TAP_RESET) // [R11]
		else $error("delay loop active while stopped");
	c_dll_locks: cover property ($rose(locked));

endmodule

// >>> core/cgc_top.sv
// core clock mode selection and cache clock divider with delay loop
// ==========================================================
// Notes on behaviour
// [R1] code 0011: pll off, bypass, 1:1 ratio
// [R2] code 1111: pll off, no clocking
// [R3] system applies only documented pll codes
// [R4] cache clock divided from core, via dll
// [R5] divisor from field: 1, 1.5, 2, 2.5, 3
// [R6] sync out returned on sync in, aligned
// [R7] software keeps cache clock above 80 MHz
// [R8] parity generation off implies checking off
// [R9] divisor field is register bits 4 to 6
// [R10] dll delays outputs up to one period
// [R11] pll off: sram clocks and sync static
`timescale 1ns/100ps
module cgc_top
	import cgc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] pll_cfg,
	input wire logic [31:0] cache_control_register,
	input wire logic cache_sync_loop_in,
	output logic pll_enable,
	output logic core_clock_on,
	output logic bus_ratio_1to1,
	output logic core_clock_out,
	output logic sram_clock_out_a,
	output logic sram_clock_out_b,
	output logic cache_sync_loop_out,
	output logic [2:0] dll_tap,
	output logic dll_locked
);

	cgc_mode_t mode;
	cgc_mode_t next_mode;
	logic [2:0] period;
	logic [2:0] next_period;
	logic [2:0] cnt;
	logic div_ref;
	logic run;
	logic [2:0] field;

	cgc_dll_if lnk ();

	assign field = cache_control_register[CGC_FIELD_MSB:CGC_FIELD_LSB]; // [R9]
	assign run = (mode != CGC_MODE_OFF) && (period != CGC_TICKS_STOP);
	assign lnk.run = run;
	assign lnk.period = period;
	assign lnk.ref_clk = div_ref;
	assign lnk.sync_in = cache_sync_loop_in; // [R6]

	cgc_dll #(
		.MAX_TAPS(CGC_MAX_TICKS)
	) i_cgc_dll (
		.core_clk(core_clk),
		.rst(rst),
		.lnk(lnk)
	);

	// ==========================================================
	// core clock mode
	always_comb begin
		case (pll_cfg)
			CGC_CFG_BYPASS: next_mode = CGC_MODE_BYPASS; // [R1]
			CGC_CFG_OFF: next_mode = CGC_MODE_OFF; // [R2]
			// reserved codes are not expected; they fall to the pll path
			default: next_mode = CGC_MODE_PLL;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode <= CGC_MODE_PLL;
			pll_enable <= 1'b0;
			core_clock_on <= 1'b0;
			bus_ratio_1to1 <= 1'b0;
		end else begin
			mode <= next_mode;
			pll_enable <= (next_mode == CGC_MODE_PLL); // [R1] [R2]
			core_clock_on <= (next_mode != CGC_MODE_OFF); // [R2]
			bus_ratio_1to1 <= (next_mode == CGC_MODE_BYPASS); // [R1]
		end
	end

	// core clock ticks straight from the reference; halted only when off
	always_ff @(posedge core_clk) begin
		if (rst || mode == CGC_MODE_OFF) begin
			core_clock_out <= 1'b0; // [R2]
		end else begin
			core_clock_out <= ~core_clock_out; // [R1]
		end
	end

	// ==========================================================
	// divisor select
	always_comb begin
		case (field)
			CGC_DIV_1: next_period = CGC_TICKS_DIV_1; // [R5]
			CGC_DIV_1P5: next_period = CGC_TICKS_DIV_1P5;
			CGC_DIV_2: next_period = CGC_TICKS_DIV_2;
			CGC_DIV_2P5: next_period = CGC_TICKS_DIV_2P5;
			CGC_DIV_3: next_period = CGC_TICKS_DIV_3;
			default: next_period = CGC_TICKS_STOP;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			period <= CGC_TICKS_STOP;
		end else begin
			period <= next_period;
		end
	end

	// ==========================================================
	// divider; odd tick counts give the half-step ratios
	always_ff @(posedge core_clk) begin
		if (rst || !run) begin
			cnt <= 3'h0;
			div_ref <= 1'b0;
		end else begin
			cnt <= (3'(cnt + 3'h1) >= period) ? 3'h0 : 3'(cnt + 3'h1); // [R4]
			div_ref <= (cnt < (period >> 1));
		end
	end

	// ==========================================================
	// pad outputs; both sram clocks and sync share one source for equal skew
	always_ff @(posedge core_clk) begin
		if (rst || !run) begin
			sram_clock_out_a <= 1'b0; // [R11]
			sram_clock_out_b <= 1'b0;
			cache_sync_loop_out <= 1'b0;
		end else begin
			sram_clock_out_a <= lnk.dly_clk; // [R4]
			sram_clock_out_b <= lnk.dly_clk;
			cache_sync_loop_out <= lnk.dly_clk; // [R6]
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dll_tap <= CGC_TAP_RESET;
			dll_locked <= 1'b0;
		end else begin
			dll_tap <= lnk.tap;
			dll_locked <= lnk.locked;
		end
	end

	// ==========================================================
	// checks: core clock mode
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_bypass_flags: assert property (pll_cfg == CGC_CFG_BYPASS
		|=> bus_ratio_1to1 && !pll_enable && core_clock_on) // [R1]
		else $error("bypass code did not give 1:1 without pll");
	a_off_no_core: assert property (pll_cfg == CGC_CFG_OFF
		|=> !core_clock_on && !pll_enable ##1 !core_clock_out) // [R2]
		else $error("off code left core clocking alive");
	a_pll_flags: assert property (pll_cfg != CGC_CFG_BYPASS && pll_cfg != CGC_CFG_OFF
		|=> pll_enable && core_clock_on && !bus_ratio_1to1) // [R1] [R2]
		else $error("pll code gave wrong mode flags");
	a_core_toggles: assert property (mode != CGC_MODE_OFF
		|=> core_clock_out != $past(core_clock_out)) // [R1]
		else $error("core clock stalled outside off mode");
	a_off_core_static: assert property (mode == CGC_MODE_OFF |=> !core_clock_out) // [R2]
		else $error("core clock moved with pll off");
	a_off_flags_hold: assert property (mode == CGC_MODE_OFF
		|-> !core_clock_on && !pll_enable && !bus_ratio_1to1) // [R2]
		else $error("off mode with clocking flags raised");
	a_ratio_no_pll: assert property (bus_ratio_1to1 |-> !pll_enable && core_clock_on) // [R1]
		else $error("1:1 ratio raised with pll in use");

	// ==========================================================
	// checks: divider
	// period checks only hold while the field stands; a change restarts the loop
	a_field_to_period: assert property (field == CGC_DIV_2P5
		|=> period == CGC_TICKS_DIV_2P5) // [R5] [R9]
		else $error("divisor field not mapped to 2.5 ratio");
	a_div_one_period: assert property (run && period == CGC_TICKS_DIV_1 && $rose(div_ref)
		##1 (run && period == CGC_TICKS_DIV_1)[*2] |-> $rose(div_ref)) // [R4] [R5]
		else $error("divide by one period wrong");
	a_div_onehalf_period: assert property (run && period == CGC_TICKS_DIV_1P5 && $rose(div_ref)
		##1 (run && period == CGC_TICKS_DIV_1P5)[*3] |-> $rose(div_ref)) // [R4] [R5]
		else $error("divide by one and a half period wrong");
	a_div_two_period: assert property (run && period == CGC_TICKS_DIV_2 && $rose(div_ref)
		##1 (run && period == CGC_TICKS_DIV_2)[*4] |-> $rose(div_ref)) // [R4] [R5]
		else $error("divide by two period wrong");
	a_div_twohalf_period: assert property (run && period == CGC_TICKS_DIV_2P5 && $rose(div_ref)
		##1 (run && period == CGC_TICKS_DIV_2P5)[*5] |-> $rose(div_ref)) // [R4] [R5]
		else $error("divide by two and a half period wrong");
	a_div_three_period: assert property (run && period == CGC_TICKS_DIV_3 && $rose(div_ref)
		##1 (run && period == CGC_TICKS_DIV_3)[*6] |-> $rose(div_ref)) // [R4] [R5]
		else $error("divide by three period wrong");

	// ==========================================================
	// checks: pads and loop status
	a_off_pads_static: assert property (mode == CGC_MODE_OFF
		|=> !sram_clock_out_a && !sram_clock_out_b && !cache_sync_loop_out) // [R11]
		else $error("sram clock moved with pll off");
	a_off_unlocks: assert property (mode == CGC_MODE_OFF |=> ##1 !dll_locked) // [R11]
		else $error("delay loop stayed locked with pll off");
	a_stop_pads_low: assert property (period == CGC_TICKS_STOP
		|=> !sram_clock_out_a && !sram_clock_out_b && !cache_sync_loop_out) // [R4]
		else $error("sram clock moved with the divisor stopped");
	a_pads_follow_dll: assert property (run |=> sram_clock_out_a == $past(lnk.dly_clk)) // [R4]
		else $error("sram clock does not follow the delay loop");
	a_pads_match: assert property (sram_clock_out_a == sram_clock_out_b
		&& sram_clock_out_b == cache_sync_loop_out) // [R6]
		else $error("sram clocks and sync out diverge");
	a_tap_mirror: assert property (1'b1 |=> dll_tap == $past(lnk.tap)
		&& dll_locked == $past(lnk.locked)) // [R10]
		else $error("delay loop status not mirrored on outputs");

	c_bypass: cover property (bus_ratio_1to1 && core_clock_on);
	c_off: cover property (mode == CGC_MODE_OFF && !core_clock_on);
	c_div_1p5: cover property (period == CGC_TICKS_DIV_1P5 && $rose(sram_clock_out_a));
	c_locked_div3: cover property (period == CGC_TICKS_DIV_3 && dll_locked);

endmodule

// >>> dv/cgc_board_loop.sv
// board trace that carries the sync clock out toward the srams and back
`timescale 1ns/100ps
module cgc_board_loop (
	input wire logic core_clk,
	input wire logic cache_sync_loop_out,
	input wire logic [2:0] lag,
	output logic cache_sync_loop_in
);
	// ==========================================================
	// trace delay
	// a longer lag models a longer route; the loop must still lock
	logic [7:0] trace;
	always_ff @(posedge core_clk) begin
		trace <= {trace[6:0], cache_sync_loop_out};
	end
	assign cache_sync_loop_in = trace[lag];
endmodule

// >>> dv/cgc_top_tb.sv
// self-checking bench for the core and cache clock generator
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module cgc_top_tb;
	import cgc_pkg::*;
	logic core_clk, rst, cache_sync_loop_in, pll_enable, core_clock_on, bus_ratio_1to1;
	logic core_clock_out, sram_clock_out_a, sram_clock_out_b, cache_sync_loop_out, dll_locked;
	logic [3:0] pll_cfg;
	logic [31:0] cache_control_register;
	logic [2:0] dll_tap, lag;
	int err_total, n_checks;

	cgc_top i_cgc_top (.core_clk(core_clk), .rst(rst), .pll_cfg(pll_cfg),
		.cache_control_register(cache_control_register),
		.cache_sync_loop_in(cache_sync_loop_in), .pll_enable(pll_enable),
		.core_clock_on(core_clock_on), .bus_ratio_1to1(bus_ratio_1to1),
		.core_clock_out(core_clock_out), .sram_clock_out_a(sram_clock_out_a),
		.sram_clock_out_b(sram_clock_out_b), .cache_sync_loop_out(cache_sync_loop_out),
		.dll_tap(dll_tap), .dll_locked(dll_locked));
	cgc_board_loop i_cgc_board_loop (.core_clk(core_clk),
		.cache_sync_loop_out(cache_sync_loop_out), .lag(lag),
		.cache_sync_loop_in(cache_sync_loop_in));

	// ==========================================================
	// clock and closing
	initial begin
		core_clk = 1'b0;
		forever #(CGC_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic set_field(logic [2:0] f);
		@(negedge core_clk);
		// every bit outside the field is set, so only bits 6:4 may matter
		cache_control_register = 32'hffff_ff8f | ({29'h0, f} << CGC_FIELD_LSB);
	endtask

	task automatic t_modes();
		logic [3:0] codes [3];
		logic a;
		codes = '{CGC_CFG_BYPASS, CGC_CFG_OFF, 4'h0};
		set_field(CGC_DIV_2);
		foreach (codes[i]) begin
			@(negedge core_clk) pll_cfg = codes[i];
			repeat (3) @(negedge core_clk);
			`CHK("pll_enable", codes[i] == 4'h0, pll_enable)
			`CHK("core_clock_on", codes[i] != CGC_CFG_OFF, core_clock_on)
			`CHK("bus_ratio_1to1", codes[i] == CGC_CFG_BYPASS, bus_ratio_1to1)
			for (int k = 0; k < 24; k++) begin
				a = core_clock_out;
				@(negedge core_clk);
				if (codes[i] == CGC_CFG_OFF) begin
					`CHK("core_clock_out", 1'b0, core_clock_out)
					`CHK("sram_clock_out_a", 1'b0, sram_clock_out_a)
					`CHK("sram_clock_out_b", 1'b0, sram_clock_out_b)
					`CHK("cache_sync_loop_out", 1'b0, cache_sync_loop_out)
				end else begin
					`CHK("core_clock_out", ~a, core_clock_out)
				end
			end
		end
		$display("test modes done");
	endtask

	task automatic t_div(logic [2:0] f, logic [2:0] l);
		int n, per, hi;
		logic prev;
		lag = l;
		set_field(f);
		// the old lock must drop before the new one is awaited
		repeat (3) @(negedge core_clk);
		`CHK("lock_cleared", 1'b0, dll_locked)
		n = 0;
		while (dll_locked !== 1'b1 && n < 800) begin
			@(negedge core_clk);
			n++;
		end
		`CHK("dll_locked", 1'b1, dll_locked)
		if (dll_locked !== 1'b1) begin
			results();
		end
		`CHK("dll_tap_in_period", 1'b1, dll_tap < 3'(f + 3'h1))
		per = 0;
		hi = 0;
		n = 0;
		prev = sram_clock_out_a;
		// start from a rising edge, then time one whole divided period
		while (!(prev === 1'b0 && sram_clock_out_a === 1'b1) && n < 20) begin
			prev = sram_clock_out_a;
			@(negedge core_clk);
			n++;
		end
		do begin
			hi += (sram_clock_out_a === 1'b1);
			per++;
			`CHK("sram_clock_out_b", sram_clock_out_a, sram_clock_out_b)
			`CHK("cache_sync_loop_out", sram_clock_out_a, cache_sync_loop_out)
			prev = sram_clock_out_a;
			@(negedge core_clk);
		end while (!(prev === 1'b0 && sram_clock_out_a === 1'b1) && per < 20);
		`CHK("divided_period", 32'(f) + 1, per)
		`CHK("divided_high", (32'(f) + 1) >> 1, hi)
		$display("test divisor %0d lag %0d done", f, l);
	endtask

	task automatic t_stop();
		logic [2:0] codes [3];
		codes = '{CGC_DIV_NONE, 3'h6, 3'h7};
		foreach (codes[i]) begin
			set_field(codes[i]);
			repeat (10) @(negedge core_clk);
			for (int k = 0; k < 20; k++) begin
				@(negedge core_clk);
				`CHK("stopped_sram_a", 1'b0, sram_clock_out_a)
				`CHK("stopped_sync_out", 1'b0, cache_sync_loop_out)
			end
		end
		$display("test stopped divisor done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		pll_cfg = 4'h0;
		cache_control_register = 32'h0000_0000;
		lag = 3'h1;
		err_total = 0;
		n_checks = 0;
		repeat (16) @(negedge core_clk);
		`CHK("reset_pll_enable", 1'b0, pll_enable)
		`CHK("reset_sram_a", 1'b0, sram_clock_out_a)
		`CHK("reset_locked", 1'b0, dll_locked)
		rst = 1'b0;
		t_modes();
		for (int f = 1; f <= 5; f++) begin
			t_div(3'(f), 3'h1);
		end
		t_div(CGC_DIV_2P5, 3'h4);
		t_div(CGC_DIV_3, 3'h6);
		t_stop();
		results();
	end
endmodule
